// [logic/register_map_consts.svh]
// Constants of the register map access block
// Contract
// - User registers live in 0x00 through 0x98
// - 0x2C-0x2F, 0x46, 0x99-0xFF are reserved
// - Reserved: no error, writes dropped, reads zero
// - Block readback returns zero for reserved words
// - Check covers 16 bits; unused bits read zero
// - Config spare fields stored, read back unchanged
// - Protocol error rejects transaction, raises alerts
// - Write to busy register ignored, reject alert set
// - CRC-8, poly 0xB2 reflected, init zero, LSB first
`ifndef REGISTER_MAP_CONSTS_SVH
`define REGISTER_MAP_CONSTS_SVH
// Address space
`define REGISTER_MAP_USER_LAST      8'h98
`define REGISTER_MAP_RSV_LO         8'h2C
`define REGISTER_MAP_RSV_HI         8'h2F
`define REGISTER_MAP_RSV_ONE        8'h46
// Register offsets
`define REGISTER_MAP_PART_VERSION   8'h00
`define REGISTER_MAP_CHAIN_ADDRESS  8'h01
`define REGISTER_MAP_STATUS_ONE     8'h02
`define REGISTER_MAP_STATUS_TWO     8'h03
`define REGISTER_MAP_CONFIG_ONE     8'h10
`define REGISTER_MAP_CONFIG_TWO     8'h11
// Field positions
`define REGISTER_MAP_S1_PEC_BIT     5
`define REGISTER_MAP_S1_INTF_BIT    4
`define REGISTER_MAP_S1_UNUSED_BIT  6
`define REGISTER_MAP_S2_RJCT_BIT    0
`define REGISTER_MAP_CFG1_SP_LSB    12
`define REGISTER_MAP_CFG2_SP_LSB    11
// Widths
`define REGISTER_MAP_CFG1_SP_W      4
`define REGISTER_MAP_CFG2_SP_W      5
// Reset values
`define REGISTER_MAP_CHAIN_RST      16'h0000
`define REGISTER_MAP_CFG1_SP_RST    4'h0
`define REGISTER_MAP_CFG2_SP_RST    5'h00
// Packet check
`define REGISTER_MAP_CRC_POLY       8'hB2
`define REGISTER_MAP_CRC_INIT       8'h00
`endif

// [logic/register_map_pkg.sv]
// Types of the register map access block
package register_map_pkg;
   // Whole block state, registered in one process
   typedef struct packed {
      logic [15:0] chain_address;   // Chain address word
      logic        pec_alert;       // Sticky packet check alert
      logic        intf_alert;      // Sticky interface alert
      logic        reject_alert;    // Sticky transaction reject alert
      logic [3:0]  cfg1_spare;      // Spare field of config one
      logic [4:0]  cfg2_spare;      // Spare field of config two
      logic        rsp_valid;       // Read answer strobe
      logic [15:0] rsp_data;        // Read answer data
      logic [7:0]  rsp_pec;         // Check byte over answer data
      logic        rsp_ack;         // Accepted write strobe
      logic        rsp_reject;      // Rejected transaction strobe
   } register_map_state_t;
endpackage

// [logic/register_map_regs.sv]
// Register map access policy and first status registers
`timescale 1ns/1ps
`include "register_map_consts.svh"
module register_map_regs #(
   parameter logic [11:0] MODEL_CODE = 12'h123, // Arbitrary value
   parameter logic [3:0]  REV_CODE   = 4'h1     // Arbitrary value
) (
   // Clock and asynchronous reset
   input  wire logic        mclk_i,
   input  wire logic        arst_n_i,
   // Decoded transaction from the link layer, one word a cycle
   input  wire logic        txn_valid_i,
   input  wire logic        txn_write_i,
   input  wire logic [7:0]  txn_addr_i,
   input  wire logic [15:0] txn_wdata_i,
   // Faults and lock state that travel with the word
   input  wire logic        txn_pec_err_i,
   input  wire logic        txn_intf_err_i,
   input  wire logic        txn_busy_i,
   // Live status bits from the measurement side
   input  wire logic [15:0] status_one_src_i,
   // Answer strobes and the read word
   output logic             rsp_valid_o,
   output logic [15:0]      rsp_data_o,
   output logic [7:0]       rsp_pec_o,
   output logic             rsp_ack_o,
   output logic             rsp_reject_o,
   // Stored register contents
   output logic [15:0]      chain_address_o,
   output logic             transaction_reject_alert_o,
   output logic [3:0]       config_one_spare_field_o,
   output logic [4:0]       config_two_spare_field_o
);

   // Limitation: the lock comes from the caller; this block cannot
   // tell which register an internal operation holds
   register_map_pkg::register_map_state_t st_reg;   // Current state
   register_map_pkg::register_map_state_t st_next;  // Next state

   // Reserved address decode, used by writes only
   // Reads of a hole fall to the default branch of read_word, which
   // gives zeros for every unmapped word as well
   function automatic logic is_reserved(input logic [7:0] a);
      is_reserved = (a > `REGISTER_MAP_USER_LAST) ||
                    ((a >= `REGISTER_MAP_RSV_LO) && (a <= `REGISTER_MAP_RSV_HI)) ||
                    (a == `REGISTER_MAP_RSV_ONE);
   endfunction

   // One byte through the reflected CRC-8, LSB first
   // The link sends each byte LSB first, so the register shifts
   // right and the reflected polynomial is folded in on a set LSB
   function automatic logic [7:0] crc8_byte(input logic [7:0] crc,
                                            input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ `REGISTER_MAP_CRC_POLY) : (c >> 1);
      end
      crc8_byte = c;
   endfunction

   // Read value of one address; unused bits are never stored
   // Every bit with neither storage nor a status source stays zero, which
   // keeps the check byte defined over the full word
   function automatic logic [15:0] read_word(
      input logic [7:0]          a,
      input register_map_pkg::register_map_state_t s,
      input logic [15:0]         src);
      logic [15:0] w;
      w = 16'h0000;
      case (a)
         `REGISTER_MAP_PART_VERSION: begin
            w = {MODEL_CODE, REV_CODE};
         end
         `REGISTER_MAP_CHAIN_ADDRESS: begin
            w = s.chain_address;
         end
         `REGISTER_MAP_STATUS_ONE: begin
            w = src;
            // Alert bits are owned here, not by the source, so a stale
            // source bit never shows up as a fault
            w[`REGISTER_MAP_S1_PEC_BIT] = s.pec_alert;
            w[`REGISTER_MAP_S1_INTF_BIT] = s.intf_alert;
            w[`REGISTER_MAP_S1_UNUSED_BIT] = 1'b0;
         end
         `REGISTER_MAP_STATUS_TWO: begin
            w[`REGISTER_MAP_S2_RJCT_BIT] = s.reject_alert;
         end
         `REGISTER_MAP_CONFIG_ONE: begin
            w[`REGISTER_MAP_CFG1_SP_LSB +: `REGISTER_MAP_CFG1_SP_W] = s.cfg1_spare;
         end
         `REGISTER_MAP_CONFIG_TWO: begin
            w[`REGISTER_MAP_CFG2_SP_LSB +: `REGISTER_MAP_CFG2_SP_W] = s.cfg2_spare;
         end
         default: begin
            // Reserved and unmapped words read all zeros
            w = 16'h0000;
         end
      endcase
      read_word = w;
   endfunction

   // Next state: transaction policy and sticky alerts
   // Priority: protocol fault, then reads, then holes, then the busy
   // lock, then a plain write. A fault wins even on a hole, so a
   // damaged word never passes as a silent drop. Only one branch
   // runs per word, so a word never both stores and refuses.
   always_comb begin
      logic        ok;
      logic        rsv;
      logic [15:0] rd;
      ok = 1'b0;
      rsv = 1'b0;
      rd = 16'h0000;
      st_next = st_reg;
      // Strobes last one cycle
      // Read data and check byte are left alone here and hold until
      // the next read
      st_next.rsp_valid = 1'b0;
      st_next.rsp_ack = 1'b0;
      st_next.rsp_reject = 1'b0;
      ok = txn_valid_i && !txn_pec_err_i && !txn_intf_err_i;
      rsv = is_reserved(txn_addr_i);
      if (txn_valid_i && !ok) begin
         // Protocol error: whole transaction dropped, only alerts and the reject strobe move
         st_next.rsp_reject = 1'b1;
      end else if (ok && !txn_write_i) begin
         // Read, also one word of a block readback
         rd = read_word(txn_addr_i, st_reg, status_one_src_i);
         st_next.rsp_valid = 1'b1;
         st_next.rsp_data = rd;
         // Check byte over the low byte and then the high byte, the
         // order in which the link sends them
         st_next.rsp_pec = crc8_byte(crc8_byte(`REGISTER_MAP_CRC_INIT, rd[7:0]),
                                     rd[15:8]);
      end else if (ok && rsv) begin
         // Reserved write: nothing stored, no answer, no error
         // Trade-off: the host gets no strobe, so it must not wait
         // for one; a timeout on its side is the only sign
         st_next.rsp_ack = 1'b0;
      end else if (ok && txn_busy_i) begin
         // Busy register keeps its content
         // The lock guards writes only; reads of a busy word still
         // answer, so the host may poll while an operation runs
         st_next.rsp_reject = 1'b1;
      end else if (ok) begin
         st_next.rsp_ack = 1'b1;
         case (txn_addr_i)
            `REGISTER_MAP_CHAIN_ADDRESS: begin
               // All sixteen bits of the chain word are writable
               st_next.chain_address = txn_wdata_i;
            end
            `REGISTER_MAP_CONFIG_ONE: begin
               // Spare fields are kept although nothing inside reads them
               st_next.cfg1_spare =
                  txn_wdata_i[`REGISTER_MAP_CFG1_SP_LSB +: `REGISTER_MAP_CFG1_SP_W];
            end
            `REGISTER_MAP_CONFIG_TWO: begin
               st_next.cfg2_spare =
                  txn_wdata_i[`REGISTER_MAP_CFG2_SP_LSB +: `REGISTER_MAP_CFG2_SP_W];
            end
            default: begin
               // Read-only or unimplemented: data discarded
            end
         endcase
         // Alert bits clear by writing one; a zero leaves a bit alone,
         // so a host may write back what it read and lose no new alert
         if (txn_addr_i == `REGISTER_MAP_STATUS_ONE) begin
            if (txn_wdata_i[`REGISTER_MAP_S1_PEC_BIT]) begin
               st_next.pec_alert = 1'b0;
            end
            if (txn_wdata_i[`REGISTER_MAP_S1_INTF_BIT]) begin
               st_next.intf_alert = 1'b0;
            end
         end
         if ((txn_addr_i == `REGISTER_MAP_STATUS_TWO) &&
             txn_wdata_i[`REGISTER_MAP_S2_RJCT_BIT]) begin
            st_next.reject_alert = 1'b0;
         end
      end
      // Set wins over a clear in the same cycle
      // A fault and a clear cannot share a cycle while one word comes
      // per cycle, but this order keeps the alerts safe should the
      // front end ever present two at once
      if (txn_valid_i && txn_pec_err_i) begin
         st_next.pec_alert = 1'b1;
      end
      if (txn_valid_i && txn_intf_err_i) begin
         st_next.intf_alert = 1'b1;
      end
      if (ok && txn_write_i && !rsv && txn_busy_i) begin
         st_next.reject_alert = 1'b1;
      end
   end

   // State register
   // Reset loads constants only; fields without a stated value come
   // up zero with the rest of the struct, so every strobe starts low
   // and no answer is seen before the first word
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_reg <= '0;
         st_reg.chain_address <= `REGISTER_MAP_CHAIN_RST;
         st_reg.cfg1_spare <= `REGISTER_MAP_CFG1_SP_RST;
         st_reg.cfg2_spare <= `REGISTER_MAP_CFG2_SP_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state flops
   // No logic between flops and pins keeps every output glitch free
   // and its timing one clock-to-out
   assign rsp_valid_o                = st_reg.rsp_valid;
   assign rsp_data_o                 = st_reg.rsp_data;
   assign rsp_pec_o                  = st_reg.rsp_pec;
   assign rsp_ack_o                  = st_reg.rsp_ack;
   assign rsp_reject_o               = st_reg.rsp_reject;
   assign chain_address_o            = st_reg.chain_address;
   assign transaction_reject_alert_o = st_reg.reject_alert;
   assign config_one_spare_field_o   = st_reg.cfg1_spare;
   assign config_two_spare_field_o   = st_reg.cfg2_spare;

endmodule // register_map_regs

// [bench/register_map_regs_sva.sv]
// Port assertions of the register map access block
`timescale 1ns/1ps
module register_map_regs_sva (
   input wire logic        mclk_i,
   input wire logic        arst_n_i,
   input wire logic        txn_valid_i,
   input wire logic        txn_write_i,
   input wire logic [7:0]  txn_addr_i,
   input wire logic [15:0] txn_wdata_i,
   input wire logic        txn_pec_err_i,
   input wire logic        txn_intf_err_i,
   input wire logic        txn_busy_i,
   input wire logic        rsp_valid_o,
   input wire logic [15:0] rsp_data_o,
   input wire logic [7:0]  rsp_pec_o,
   input wire logic        rsp_ack_o,
   input wire logic        rsp_reject_o,
   input wire logic [15:0] chain_address_o,
   input wire logic        transaction_reject_alert_o,
   input wire logic [3:0]  config_one_spare_field_o,
   input wire logic [4:0]  config_two_spare_field_o
);
   logic rsv; // Address falls in a reserved hole
   logic err; // Any protocol fault on this word
   assign rsv = (txn_addr_i inside {[8'h2C:8'h2F]}) ||
                txn_addr_i == 8'h46 || txn_addr_i > 8'h98;
   assign err = txn_pec_err_i || txn_intf_err_i;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_ok; txn_valid_i && !err; endsequence
   sequence s_wr; s_ok ##0 (txn_write_i && !rsv); endsequence
   property p_err_rej; txn_valid_i && err |=> rsp_reject_o && !rsp_valid_o;
   endproperty
   a_err_rej: assert property (p_err_rej) else $error("fault not refused");
   property p_err_keep; txn_valid_i && err |=> $stable(chain_address_o);
   endproperty
   a_err_keep: assert property (p_err_keep) else $error("fault stored");
   property p_rd_ans; s_ok ##0 !txn_write_i |=> rsp_valid_o; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read skipped");
   property p_rsv_rd; s_ok ##0 (!txn_write_i && rsv) |=>
      rsp_data_o == 16'h0000 && rsp_pec_o == 8'h00; endproperty
   a_rsv_rd: assert property (p_rsv_rd) else $error("hole not zero");
   property p_rsv_wr; s_ok ##0 (txn_write_i && rsv) |=>
      !rsp_ack_o && !rsp_reject_o; endproperty
   a_rsv_wr: assert property (p_rsv_wr) else $error("hole answered");
   property p_busy; s_wr ##0 txn_busy_i |=>
      rsp_reject_o && transaction_reject_alert_o; endproperty
   a_busy: assert property (p_busy) else $error("busy not refused");
   property p_busy_keep; s_wr ##0 txn_busy_i |=> $stable(chain_address_o)
      && $stable(config_one_spare_field_o); endproperty
   a_busy_keep: assert property (p_busy_keep) else $error("busy stored");
   property p_chain; s_wr ##0 (!txn_busy_i && txn_addr_i == 8'h01) |=>
      chain_address_o == $past(txn_wdata_i); endproperty
   a_chain: assert property (p_chain) else $error("word not kept");
   property p_cfg1; s_wr ##0 (!txn_busy_i && txn_addr_i == 8'h10) |=>
      config_one_spare_field_o == 4'($past(txn_wdata_i) >> 12); endproperty
   a_cfg1: assert property (p_cfg1) else $error("spare not kept");
   property p_cfg2; s_wr ##0 (!txn_busy_i && txn_addr_i == 8'h11) |=>
      config_two_spare_field_o == 5'($past(txn_wdata_i) >> 11); endproperty
   a_cfg2: assert property (p_cfg2) else $error("spare two lost");
endmodule // register_map_regs_sva
bind register_map_regs register_map_regs_sva register_map_regs_sva_inst (.*);

// [bench/register_map_host.sv]
// Host model issuing decoded words to the block
`timescale 1ns/1ps
module register_map_host (
   input  wire logic        mclk_i,
   output logic             txn_valid_o,
   output logic             txn_write_o,
   output logic [7:0]       txn_addr_o,
   output logic [15:0]      txn_wdata_o,
   output logic             txn_pec_err_o,
   output logic             txn_intf_err_o,
   output logic             txn_busy_o
);
   initial {txn_valid_o, txn_write_o, txn_addr_o, txn_wdata_o,
            txn_pec_err_o, txn_intf_err_o, txn_busy_o} = '0;
   // One word; busy or reserved writes only when a test asks
   task automatic txn(input logic w, input logic [7:0] a,
                      input logic [15:0] d, input logic pe, ie, bz);
      @(posedge mclk_i);
      {txn_valid_o, txn_write_o, txn_addr_o} <= {1'b1, w, a};
      {txn_wdata_o, txn_pec_err_o, txn_intf_err_o} <= {d, pe, ie};
      txn_busy_o <= bz;
      @(posedge mclk_i);
      txn_valid_o <= 1'b0;
      txn_addr_o  <= ~a; // Released lines do not keep the old value
      txn_wdata_o <= ~d;
      #1;
   endtask
   // Block readback: one read a cycle, addresses counted up
   task automatic stream(input logic [7:0] a, input int n);
      @(posedge mclk_i);
      {txn_valid_o, txn_write_o, txn_addr_o} <= {1'b1, 1'b0, a};
      {txn_pec_err_o, txn_intf_err_o, txn_busy_o} <= 3'b000;
      for (int k = 1; k < n; k++) begin
         @(posedge mclk_i);
         txn_addr_o <= a + 8'(k);
      end
      @(posedge mclk_i);
      txn_valid_o <= 1'b0;
      txn_addr_o  <= ~a;
      #1;
   endtask
   // Check byte, LSB first, low byte first
   function automatic logic [7:0] crc(input logic [15:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 16; i++) begin
         c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'hB2 : 8'h00);
      end
      return c;
   endfunction
endmodule // register_map_host

// [bench/register_map_regs_test.sv]
// Self-checking bench of the register map access block
`timescale 1ns/1ps
module register_map_regs_test;
   typedef struct packed {
      logic w; logic [7:0] a; logic [15:0] d; logic [15:0] e;
   } register_map_row_t; // Write flag, address, data, expected value
   logic mclk_i, arst_n_i, tv, tw, tpe, tie, tbz, rv, ra, rj, al;
   logic [7:0]  ta, pec;
   logic [15:0] td, rd, ch;
   logic [3:0]  c1;
   logic [4:0]  c2;
   // Block readback across the top hole and on to the first words
   logic [15:0] blk_exp [4] = '{16'h0000, 16'h0000, 16'h1231, 16'hA5C3};
   int errors = 0, check_count = 0, cyc = 0;
   register_map_row_t rows[14] = '{'{1,8'h01,16'hA5C3,1}, '{0,8'h01,0,16'hA5C3},
      '{1,8'h10,16'hFFFF,1}, '{0,8'h10,0,16'hF000}, '{1,8'h11,16'hFFFF,1},
      '{0,8'h11,0,16'hF800}, '{1,8'h2C,16'hFFFF,0}, '{0,8'h2C,0,0},
      '{0,8'h2F,0,0}, '{0,8'h46,0,0}, '{0,8'h99,0,0}, '{0,8'hFF,0,0},
      '{0,8'h98,0,0}, '{0,8'h00,0,16'h1231}};
   register_map_host register_map_host_inst (.mclk_i(mclk_i), .txn_valid_o(tv),
      .txn_write_o(tw), .txn_addr_o(ta), .txn_wdata_o(td),
      .txn_pec_err_o(tpe), .txn_intf_err_o(tie), .txn_busy_o(tbz));
   register_map_regs register_map_regs_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
      .txn_valid_i(tv), .txn_write_i(tw), .txn_addr_i(ta),
      .txn_wdata_i(td), .txn_pec_err_i(tpe), .txn_intf_err_i(tie),
      .txn_busy_i(tbz), .status_one_src_i(16'hFFFF), .rsp_valid_o(rv),
      .rsp_data_o(rd), .rsp_pec_o(pec), .rsp_ack_o(ra), .rsp_reject_o(rj),
      .chain_address_o(ch), .transaction_reject_alert_o(al),
      .config_one_spare_field_o(c1), .config_two_spare_field_o(c2));
   // 25 ns clock and a hang guard
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         give_verdict();
      end
   end
   task automatic check_val(input logic [15:0] got, exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("errors=%0d check_count=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Reset, table of plain words, then refusals
   initial begin
      arst_n_i = 1'b0;
      repeat (6) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      #1 check_val(ch, 16'h0000);
      check_val({12'h000, rv, ra, rj, al}, 16'h0000);
      check_val(rd, 16'h0000);
      check_val({4'h0, pec, c1}, 16'h0000);
      foreach (rows[i]) begin
         register_map_host_inst.txn(rows[i].w, rows[i].a, rows[i].d, 0, 0, 0);
         if (rows[i].w) check_val({15'h0, ra}, rows[i].e);
         else begin
            check_val(rd, rows[i].e);
            check_val({15'h0, rv}, 16'h0001);
            check_val(pec, register_map_host_inst.crc(rows[i].e));
         end
      end
      check_val({c1, 7'h00, c2}, 16'hF01F);
      fork
         register_map_host_inst.stream(8'hFE, 4);
         begin
            @(posedge mclk_i);
            foreach (blk_exp[k]) begin
               @(posedge mclk_i);
               #1 check_val(rd, blk_exp[k]);
               check_val({15'h0, rv}, 16'h0001);
            end
         end
      join
      register_map_host_inst.txn(1, 8'h01, 16'h1234, 0, 0, 1);
      check_val({14'h0, rj, al}, 16'h0003);
      check_val(ch, 16'hA5C3);
      register_map_host_inst.txn(1, 8'h2C, 16'hFFFF, 1, 0, 0);
      check_val({15'h0, rj}, 16'h0001);
      register_map_host_inst.txn(0, 8'h01, 16'h0000, 0, 1, 0);
      check_val({14'h0, rv, rj}, 16'h0001);
      register_map_host_inst.txn(0, 8'h02, 16'h0000, 0, 0, 0);
      check_val(rd, 16'hFFBF);
      register_map_host_inst.txn(0, 8'h03, 16'h0000, 0, 0, 0);
      check_val(rd, 16'h0001);
      register_map_host_inst.txn(1, 8'h03, 16'hFFFF, 0, 0, 0);
      register_map_host_inst.txn(0, 8'h03, 16'h0000, 0, 0, 0);
      check_val({rd[14:0], al}, 16'h0000);
      register_map_host_inst.txn(1, 8'h02, 16'h0030, 0, 0, 0);
      check_val({15'h0, ra}, 16'h0001);
      register_map_host_inst.txn(0, 8'h02, 16'h0000, 0, 0, 0);
      check_val(rd, 16'hFF8F);
      give_verdict();
   end
endmodule // register_map_regs_test
